// >>> core/tbfd_frame_ctrl.sv
// Type B frame delimiter control with register slave, receive filter and transmit framer.
// Overview of operation
// - Start delimiter required: streams without one are discarded.
// - Start delimiter optional: accept both, never store the delimiter.
// - End delimiter required: stream ending without one flags a protocol error.
// - End delimiter optional: accept both, never store the delimiter.
// - Width one, adjust zero: maximum delimiter lengths.
// - Width zero, adjust zero: minimum delimiter lengths.
// - Width and adjust one: lows 11 etu minus 8, high 2 etu plus 8.
// - Start suppress bit set: no start delimiter sent.
// - End suppress bit set: no end delimiter sent.
// - Guard field adds zero to three bit times between characters.
// - Bit 5 is reserved and has no effect.
// - Framing register resets to all zeros.
`timescale 1ns/100ps
`default_nettype none
module tbfd_frame_ctrl
    import tbfd_pkg::*;
(
    input wire logic        sys_clk_in,
    input wire logic        rst_n_in,
    input wire logic [7:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [3:0]  avs_byteenable_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0]     avs_readdata_out,
    output logic            avs_waitrequest_out,
    input wire logic        delimiter_adjust_enable_in,
    input wire logic        fc_tick_in,
    input wire logic        rx_sof_in,
    input wire logic        rx_eof_in,
    input wire logic        rx_end_in,
    input wire logic        rx_byte_valid_in,
    input wire logic [7:0]  rx_byte_in,
    output logic            rx_byte_ready_out,
    output logic            rx_data_valid_out,
    input wire logic        rx_data_ready_in,
    output logic [7:0]      rx_data_out,
    output logic            rx_protocol_error_out,
    input wire logic        tx_valid_in,
    input wire logic        tx_last_in,
    input wire logic [7:0]  tx_data_in,
    output logic            tx_ready_out,
    output logic            tx_bit_out,
    output logic            tx_busy_out
);
    typedef struct packed {
        tbfd_cfg_t      cfg;
        logic           proto_err;
        logic           discarded;
        tbfd_rx_state_t rx_state;
        logic           eof_seen;
        logic           err_pulse;
        logic           ack;
        logic [7:0]     rdata;
    } tbfd_top_st_t;

    tbfd_top_st_t st;
    tbfd_top_st_t next_st;

    tbfd_stream_if #(.W(`TBFD_DATA_W))     rx_wr ();
    tbfd_stream_if #(.W(`TBFD_DATA_W))     rx_rd ();
    tbfd_stream_if #(.W(`TBFD_DATA_W + 1)) tx_bytes ();

    logic       req;
    logic       hit_cfg;
    logic       hit_stat;
    logic       store;
    logic       byte_take;
    logic       err_set;
    logic       disc_set;
    logic       tx_busy;
    logic [7:0] status;

    tbfd_fifo #(
        .W     (`TBFD_DATA_W),
        .DEPTH (`TBFD_FIFO_DEPTH)
    ) u_rx_fifo (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .wr_side    (rx_wr),
        .rd_side    (rx_rd)
    );

    tbfd_tx_framer u_tx (
        .sys_clk_in                 (sys_clk_in),
        .rst_n_in                   (rst_n_in),
        .cfg_in                     (st.cfg),
        .delimiter_adjust_enable_in (delimiter_adjust_enable_in),
        .fc_tick_in                 (fc_tick_in),
        .byte_side                  (tx_bytes),
        .tx_bit_out                 (tx_bit_out),
        .busy_out                   (tx_busy)
    );

    assign tx_bytes.valid = tx_valid_in;
    assign tx_bytes.data  = {tx_last_in, tx_data_in};
    assign tx_ready_out   = tx_bytes.ready;
    assign tx_busy_out    = tx_busy;

    assign rx_data_valid_out = rx_rd.valid;
    assign rx_data_out       = rx_rd.data;
    assign rx_rd.ready       = rx_data_ready_in;

    assign store = (st.rx_state == RX_FRAME && !st.eof_seen)
                || (st.rx_state == RX_IDLE && !st.cfg.rx_start_marker_required && !rx_sof_in);
    assign rx_wr.valid = rx_byte_valid_in && store;
    assign rx_wr.data  = rx_byte_in;
    // Dropped bytes are always taken so a discarded stream never stalls the demodulator.
    assign rx_byte_ready_out = store ? rx_wr.ready : 1'b1;
    assign byte_take = rx_byte_valid_in && rx_byte_ready_out;

    assign req      = avs_read_in || avs_write_in;
    assign hit_cfg  = (avs_address_in == {`TBFD_FRAMING_IDX, 2'b00});
    assign hit_stat = (avs_address_in == {`TBFD_STATUS_IDX, 2'b00});
    assign avs_waitrequest_out   = req && !st.ack;
    assign avs_readdata_out      = {24'h000000, st.rdata};
    assign rx_protocol_error_out = st.err_pulse;

    always_comb
    begin
        status = 8'h00;
        status[`TBFD_ST_PROTO_ERR] = st.proto_err;
        status[`TBFD_ST_DISCARD]   = st.discarded;
        status[`TBFD_ST_RX_BUSY]   = (st.rx_state != RX_IDLE);
        status[`TBFD_ST_TX_BUSY]   = tx_busy;
    end

    always_comb
    begin
        next_st = st;
        next_st.err_pulse = 1'b0;
        err_set  = 1'b0;
        disc_set = 1'b0;
        case (st.rx_state)
            RX_IDLE:
            begin
                if (rx_sof_in)
                begin
                    next_st.rx_state = RX_FRAME;
                    next_st.eof_seen = rx_eof_in;
                end
                else if ((byte_take || rx_eof_in) && st.cfg.rx_start_marker_required)
                begin
                    next_st.rx_state = RX_DISCARD;
                    disc_set         = 1'b1;
                end
                else if (byte_take || rx_eof_in)
                begin
                    next_st.rx_state = RX_FRAME;
                    next_st.eof_seen = rx_eof_in;
                end
            end
            RX_FRAME:
            begin
                if (rx_eof_in)
                begin
                    next_st.eof_seen = 1'b1;
                end
            end
            default:
            begin
                next_st.rx_state = RX_DISCARD;
            end
        endcase
        if (rx_end_in && (st.rx_state != RX_IDLE || next_st.rx_state != RX_IDLE))
        begin
            if (next_st.rx_state == RX_FRAME && st.cfg.rx_end_marker_required
                && !next_st.eof_seen)
            begin
                err_set           = 1'b1;
                next_st.err_pulse = 1'b1;
            end
            next_st.rx_state = RX_IDLE;
            next_st.eof_seen = 1'b0;
        end
        next_st.ack = 1'b0;
        if (req && !st.ack)
        begin
            next_st.ack = 1'b1;
            if (hit_cfg)
            begin
                next_st.rdata = st.cfg;
            end
            else if (hit_stat)
            begin
                next_st.rdata = status;
            end
            else
            begin
                next_st.rdata = 8'h00;
            end
        end
        // The write lands on the edge that also completes the bus cycle.
        if (avs_write_in && st.ack && avs_byteenable_in[0])
        begin
            if (hit_cfg)
            begin
                next_st.cfg = avs_writedata_in[7:0] & `TBFD_FRAMING_WMASK;
            end
            else if (hit_stat)
            begin
                next_st.proto_err = st.proto_err & ~avs_writedata_in[`TBFD_ST_PROTO_ERR];
                next_st.discarded = st.discarded & ~avs_writedata_in[`TBFD_ST_DISCARD];
            end
        end
        // A new event beats a clear in the same cycle.
        if (err_set)
        begin
            next_st.proto_err = 1'b1;
        end
        if (disc_set)
        begin
            next_st.discarded = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st          <= '0;
            st.cfg      <= `TBFD_FRAMING_RST;
            st.rx_state <= RX_IDLE;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

// >>> inc/tbfd_map.svh
// Register map, field positions, reset values and delimiter timing of the framer.
`ifndef TBFD_MAP_SVH
`define TBFD_MAP_SVH
`define TBFD_FRAMING_IDX      6'h1E
`define TBFD_STATUS_IDX       6'h30
`define TBFD_FRAMING_RST      8'h00
`define TBFD_FRAMING_WMASK    8'hDF
`define TBFD_ST_PROTO_ERR     0
`define TBFD_ST_DISCARD       1
`define TBFD_ST_RX_BUSY       2
`define TBFD_ST_TX_BUSY       3
`define TBFD_ETU_FC           128
`define TBFD_ADJ_FC           8
`define TBFD_SOF_LO_MIN_ETU   10
`define TBFD_SOF_LO_MAX_ETU   11
`define TBFD_SOF_HI_MIN_ETU   2
`define TBFD_SOF_HI_MAX_ETU   3
`define TBFD_EOF_LO_MIN_ETU   10
`define TBFD_EOF_LO_MAX_ETU   11
`define TBFD_CHAR_BITS        10
`define TBFD_DATA_W           8
`define TBFD_FIFO_DEPTH       32
`endif

// >>> inc/tbfd_pkg.sv
// Types shared by the framer modules.
`default_nettype none
package tbfd_pkg;
    `include "tbfd_map.svh"
    typedef struct packed {
        logic       rx_start_marker_required;
        logic       rx_end_marker_required;
        logic       reserved;
        logic       delimiter_width_select;
        logic       tx_start_marker_suppress;
        logic       tx_end_marker_suppress;
        logic [1:0] tx_extra_guard_time;
    } tbfd_cfg_t;
    typedef enum logic [1:0] {RX_IDLE, RX_FRAME, RX_DISCARD} tbfd_rx_state_t;
    typedef enum logic [2:0] {TX_IDLE, TX_SOF_LO, TX_SOF_HI, TX_CHAR, TX_EGT, TX_WAIT,
                              TX_EOF_LO} tbfd_tx_state_t;
endpackage
`default_nettype wire

// >>> inc/tbfd_stream_if.sv
// Valid and ready stream carrier between the framer modules.
`timescale 1ns/100ps
`default_nettype none
interface tbfd_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> core/tbfd_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
`default_nettype none
module tbfd_fifo
    import tbfd_pkg::*;
#(
    parameter int W     = 8,
    parameter int DEPTH = 32
)
(
    input wire logic     sys_clk_in,
    input wire logic     rst_n_in,
    tbfd_stream_if.snk   wr_side,
    tbfd_stream_if.src   rd_side
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } tbfd_fifo_st_t;

    tbfd_fifo_st_t st;
    tbfd_fifo_st_t next_st;
    logic [W-1:0]  mem [DEPTH];
    logic          full;
    logic          empty;

    assign full  = (st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]);
    assign empty = (st.wp == st.rp);
    assign wr_side.ready = !full;
    assign rd_side.valid = !empty;
    assign rd_side.data  = mem[st.rp[AW-1:0]];

    always_comb
    begin
        next_st = st;
        if (wr_side.valid && !full)
        begin
            next_st.wp = st.wp + 1'b1;
        end
        if (rd_side.ready && !empty)
        begin
            next_st.rp = st.rp + 1'b1;
        end
    end

    // The storage has no reset so it maps onto plain RAM.
    always_ff @(posedge sys_clk_in)
    begin
        if (wr_side.valid && !full)
        begin
            mem[st.wp[AW-1:0]] <= wr_side.data;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

// >>> core/tbfd_tx_framer.sv
// Transmit framer: start delimiter, characters with guard time, end delimiter.
`timescale 1ns/100ps
`default_nettype none
module tbfd_tx_framer
    import tbfd_pkg::*;
(
    input wire logic       sys_clk_in,
    input wire logic       rst_n_in,
    input wire tbfd_cfg_t  cfg_in,
    input wire logic       delimiter_adjust_enable_in,
    input wire logic       fc_tick_in,
    tbfd_stream_if.snk     byte_side,
    output logic           tx_bit_out,
    output logic           busy_out
);
    localparam logic [11:0] ETU     = 12'(`TBFD_ETU_FC);
    localparam logic [11:0] ADJ     = 12'(`TBFD_ADJ_FC);
    localparam logic [11:0] SLO_MIN = 12'(`TBFD_SOF_LO_MIN_ETU * `TBFD_ETU_FC);
    localparam logic [11:0] SLO_MAX = 12'(`TBFD_SOF_LO_MAX_ETU * `TBFD_ETU_FC);
    localparam logic [11:0] SHI_MIN = 12'(`TBFD_SOF_HI_MIN_ETU * `TBFD_ETU_FC);
    localparam logic [11:0] SHI_MAX = 12'(`TBFD_SOF_HI_MAX_ETU * `TBFD_ETU_FC);
    localparam logic [11:0] ELO_MIN = 12'(`TBFD_EOF_LO_MIN_ETU * `TBFD_ETU_FC);
    localparam logic [11:0] ELO_MAX = 12'(`TBFD_EOF_LO_MAX_ETU * `TBFD_ETU_FC);
    localparam logic [3:0]  LASTBIT = 4'(`TBFD_CHAR_BITS - 1);

    typedef struct packed {
        tbfd_tx_state_t state;
        logic [11:0]    cnt;
        logic [3:0]     bits;
        logic [9:0]     shreg;
        logic           last;
        logic [1:0]     egt_left;
        logic           line;
    } tbfd_tx_st_t;

    tbfd_tx_st_t st;
    tbfd_tx_st_t next_st;
    logic [11:0] sof_lo;
    logic [11:0] sof_hi;
    logic [11:0] eof_lo;
    logic        take;
    logic        phase_end;

    always_comb
    begin
        if (cfg_in.delimiter_width_select && delimiter_adjust_enable_in)
        begin
            sof_lo = SLO_MAX - ADJ;
            sof_hi = SHI_MIN + ADJ;
            eof_lo = ELO_MAX - ADJ;
        end
        else if (cfg_in.delimiter_width_select)
        begin
            sof_lo = SLO_MAX;
            sof_hi = SHI_MAX;
            eof_lo = ELO_MAX;
        end
        else
        begin
            sof_lo = SLO_MIN;
            sof_hi = SHI_MIN;
            eof_lo = ELO_MIN;
        end
    end

    assign byte_side.ready = (st.state == TX_IDLE) || (st.state == TX_WAIT);
    assign take      = byte_side.ready && byte_side.valid;
    assign phase_end = fc_tick_in && (st.cnt == 12'h000);
    assign tx_bit_out = st.line;
    assign busy_out   = (st.state != TX_IDLE);

    always_comb
    begin
        next_st = st;
        if (fc_tick_in && st.cnt != 12'h000)
        begin
            next_st.cnt = st.cnt - 12'h001;
        end
        case (st.state)
            TX_IDLE, TX_WAIT:
            begin
                if (take)
                begin
                    next_st.shreg = {1'b1, byte_side.data[7:0], 1'b0};
                    next_st.last  = byte_side.data[8];
                    next_st.bits  = 4'h0;
                    if (st.state == TX_IDLE && !cfg_in.tx_start_marker_suppress)
                    begin
                        next_st.state = TX_SOF_LO;
                        next_st.cnt   = sof_lo - 12'h001;
                    end
                    else
                    begin
                        next_st.state = TX_CHAR;
                        next_st.cnt   = ETU - 12'h001;
                    end
                end
            end
            TX_SOF_LO:
            begin
                if (phase_end)
                begin
                    next_st.state = TX_SOF_HI;
                    next_st.cnt   = sof_hi - 12'h001;
                end
            end
            TX_SOF_HI:
            begin
                if (phase_end)
                begin
                    next_st.state = TX_CHAR;
                    next_st.cnt   = ETU - 12'h001;
                end
            end
            TX_CHAR:
            begin
                if (phase_end)
                begin
                    next_st.cnt   = ETU - 12'h001;
                    next_st.shreg = {1'b1, st.shreg[9:1]};
                    next_st.bits  = st.bits + 4'h1;
                    if (st.bits == LASTBIT)
                    begin
                        if (st.last && cfg_in.tx_end_marker_suppress)
                        begin
                            next_st.state = TX_IDLE;
                        end
                        else if (st.last)
                        begin
                            next_st.state = TX_EOF_LO;
                            next_st.cnt   = eof_lo - 12'h001;
                        end
                        else if (cfg_in.tx_extra_guard_time != 2'b00)
                        begin
                            next_st.state    = TX_EGT;
                            next_st.egt_left = cfg_in.tx_extra_guard_time;
                        end
                        else
                        begin
                            next_st.state = TX_WAIT;
                        end
                    end
                end
            end
            TX_EGT:
            begin
                if (phase_end)
                begin
                    next_st.cnt      = ETU - 12'h001;
                    next_st.egt_left = st.egt_left - 2'b01;
                    if (st.egt_left == 2'b01)
                    begin
                        next_st.state = TX_WAIT;
                    end
                end
            end
            TX_EOF_LO:
            begin
                if (phase_end)
                begin
                    next_st.state = TX_IDLE;
                end
            end
            default:
            begin
                next_st.state = TX_IDLE;
            end
        endcase
        case (next_st.state)
            TX_SOF_LO, TX_EOF_LO: next_st.line = 1'b0;
            TX_CHAR:              next_st.line = next_st.shreg[0];
            default:              next_st.line = 1'b1;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st       <= '0;
            st.state <= TX_IDLE;
            st.line  <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

// >>> tb/tbfd_frame_ctrl_assertions.sv
// Port checker of the Type B frame delimiter control.
`timescale 1ns/100ps
`default_nettype none
module tbfd_frame_ctrl_assertions (
    input wire logic        sys_clk_in,
    input wire logic        rst_n_in,
    input wire logic [7:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic        rx_end_in,
    input wire logic        rx_protocol_error_out,
    input wire logic        rx_data_valid_out,
    input wire logic        tx_valid_in,
    input wire logic        tx_ready_out,
    input wire logic        tx_bit_out,
    input wire logic        tx_busy_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_take;
        tx_valid_in && tx_ready_out && !tx_busy_out;
    endsequence
    sequence s_low;
        !tx_bit_out && tx_busy_out;
    endsequence
    a_err_one_cycle: assert property (rx_protocol_error_out |=> !rx_protocol_error_out)
        else $error("error pulse too long");
    a_err_after_end: assert property (rx_protocol_error_out |-> $past(rx_end_in))
        else $error("error pulse without stream end");
    a_take_line_low: assert property (s_take |=> s_low)
        else $error("line not low after take");
    a_low_min_len: assert property ($fell(tx_bit_out) |=> !tx_bit_out [*8])
        else $error("low phase too short");
    a_idle_high_end: assert property ($fell(tx_busy_out) |-> tx_bit_out)
        else $error("line not high at frame end");
    a_reserved_zero: assert property (avs_read_in && !avs_waitrequest_out &&
        avs_address_in == 8'h78 |-> avs_readdata_out[5] == 1'b0)
        else $error("reserved bit read as one");
    a_reset_idle: assert property ($rose(rst_n_in) |-> tx_bit_out && !tx_busy_out
        && !rx_data_valid_out)
        else $error("outputs not idle after reset");
    a_bus_one_wait: assert property (avs_read_in && avs_waitrequest_out
        |=> !avs_waitrequest_out)
        else $error("read answer late");
endmodule
bind tbfd_frame_ctrl tbfd_frame_ctrl_assertions i_chk (.sys_clk_in, .rst_n_in,
    .avs_address_in, .avs_read_in, .avs_readdata_out, .avs_waitrequest_out, .rx_end_in,
    .rx_protocol_error_out, .rx_data_valid_out, .tx_valid_in, .tx_ready_out, .tx_bit_out,
    .tx_busy_out);
`default_nettype wire

// >>> tb/tbfd_card_model.sv
// Card side: feeds the receive path and times the transmitted line.
`timescale 1ns/100ps
`default_nettype none
module tbfd_card_model (
    input wire logic       sys_clk_in,
    input wire logic       tx_bit_in,
    input wire logic       rx_byte_ready_in,
    output var logic       rx_sof_out,
    output var logic       rx_eof_out,
    output var logic       rx_end_out,
    output var logic       rx_byte_valid_out,
    output var logic [7:0] rx_byte_out
);
    int   lows[$];
    int   highs[$];
    int   run = 0;
    logic lvl = 1'b1;
    initial
    begin
        {rx_sof_out, rx_eof_out, rx_end_out, rx_byte_valid_out} = 4'h0;
        rx_byte_out = 8'h5A;
    end
    // Phase lengths in clocks; a level change closes the run.
    always @(posedge sys_clk_in)
    begin
        if (tx_bit_in === lvl)
            run++;
        else
        begin
            if (lvl)
                highs.push_back(run);
            else
                lows.push_back(run);
            run = 1;
            lvl = tx_bit_in;
        end
    end
    task automatic send(input logic sof, input int n, input logic eof);
        @(posedge sys_clk_in);
        rx_sof_out <= sof;
        @(posedge sys_clk_in);
        rx_sof_out <= 1'b0;
        for (int i = 0; i < n; i++)
        begin
            rx_byte_valid_out <= 1'b1;
            rx_byte_out       <= 8'hA0 + 8'(i);
            do @(posedge sys_clk_in); while (rx_byte_ready_in !== 1'b1);
        end
        // A released byte lane shows a changed value, never the stale one.
        rx_byte_valid_out <= 1'b0;
        rx_byte_out       <= ~rx_byte_out;
        rx_eof_out        <= eof;
        @(posedge sys_clk_in);
        rx_eof_out <= 1'b0;
        rx_end_out <= 1'b1;
        @(posedge sys_clk_in);
        rx_end_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> tb/tbfd_frame_ctrl_tb.sv
// Self-checking bench of the Type B frame delimiter control.
`timescale 1ns/100ps
`default_nettype none
module tbfd_frame_ctrl_tb;
    logic        sys_clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [7:0]  avs_address_in = 8'h00;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [3:0]  avs_byteenable_in = 4'hF;
    logic [31:0] avs_writedata_in = 32'h0;
    logic        delimiter_adjust_enable_in = 1'b0;
    logic        fc_tick_in = 1'b1;
    logic        rx_data_ready_in = 1'b1;
    logic        tx_valid_in = 1'b0;
    logic        tx_last_in = 1'b0;
    logic [7:0]  tx_data_in = 8'h00;
    logic [31:0] q;
    wire logic [31:0] avs_readdata_out;
    wire logic [7:0]  rx_byte_in, rx_data_out;
    wire logic avs_waitrequest_out, rx_sof_in, rx_eof_in, rx_end_in, rx_byte_valid_in;
    wire logic rx_byte_ready_out, rx_data_valid_out, rx_protocol_error_out;
    wire logic tx_ready_out, tx_bit_out, tx_busy_out;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n_perr = 0;
    int n_rx = 0;
    tbfd_frame_ctrl i_dut (.sys_clk_in, .rst_n_in, .avs_address_in, .avs_read_in,
        .avs_write_in, .avs_byteenable_in, .avs_writedata_in, .avs_readdata_out,
        .avs_waitrequest_out, .delimiter_adjust_enable_in, .fc_tick_in, .rx_sof_in,
        .rx_eof_in, .rx_end_in, .rx_byte_valid_in, .rx_byte_in, .rx_byte_ready_out,
        .rx_data_valid_out, .rx_data_ready_in, .rx_data_out, .rx_protocol_error_out,
        .tx_valid_in, .tx_last_in, .tx_data_in, .tx_ready_out, .tx_bit_out, .tx_busy_out);
    tbfd_card_model card (.sys_clk_in, .tx_bit_in(tx_bit_out),
        .rx_byte_ready_in(rx_byte_ready_out), .rx_sof_out(rx_sof_in), .rx_eof_out(rx_eof_in),
        .rx_end_out(rx_end_in), .rx_byte_valid_out(rx_byte_valid_in), .rx_byte_out(rx_byte_in));
    always #4 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in)
    begin
        cycles++;
        fc_tick_in <= ~fc_tick_in;
        n_perr += (rx_protocol_error_out === 1'b1);
        n_rx += (rx_data_valid_out === 1'b1 && rx_data_ready_in === 1'b1);
        if (cycles == 90000)
        begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic wrap_up;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("mismatch %s expected %0h seen %0h", what, e, g);
        end
    endtask
    // Ticks come every second clock; a phase may be one clock off.
    task automatic near(input string what, input int e, input int g);
        chk(what, 32'(2 * e), (g + 1 == 2 * e || g == 2 * e + 1) ? 32'(2 * e) : 32'(g));
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        @(posedge sys_clk_in);
        avs_address_in    <= a;
        avs_write_in      <= w;
        avs_read_in       <= !w;
        avs_writedata_in  <= d;
        avs_byteenable_in <= be;
        do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        avs_read_in  <= 1'b0;
        avs_write_in <= 1'b0;
    endtask
    task automatic setcfg(input logic [7:0] v, input logic adj);
        bus(1'b1, 8'h78, {24'h0, v}, 4'hF);
        delimiter_adjust_enable_in <= adj & v[4];
    endtask
    task automatic tx_frame(input int n);
        card.lows.delete();
        card.highs.delete();
        for (int i = 0; i < n; i++)
        begin
            tx_valid_in <= 1'b1;
            tx_data_in  <= 8'hFF;
            tx_last_in  <= (i == n - 1);
            do @(posedge sys_clk_in); while (tx_ready_out !== 1'b1);
        end
        tx_valid_in <= 1'b0;
        do @(posedge sys_clk_in); while (tx_busy_out !== 1'b0);
        repeat (4) @(posedge sys_clk_in);
    endtask
    task automatic t_regs;
        bus(1'b0, 8'h78, 32'h0, 4'hF);
        chk("framing reset", 32'h0, q);
        bus(1'b1, 8'h78, 32'hFF, 4'hF);
        bus(1'b1, 8'h78, 32'h00, 4'hE);
        bus(1'b0, 8'h78, 32'h0, 4'hF);
        chk("framing readback", 32'hDF, q);
        bus(1'b0, 8'h04, 32'h0, 4'hF);
        chk("unmapped read", 32'h0, q);
    endtask
    task automatic t_delims;
        logic [7:0] v[3] = '{8'h20, 8'h10, 8'h30};
        int lo[3] = '{1280, 1408, 1400};
        int hi[3] = '{256, 384, 264};
        for (int k = 0; k < 3; k++)
        begin
            setcfg(v[k], k == 2);
            tx_frame(1);
            near("start low", lo[k], card.lows[0]);
            near("start high", hi[k], card.highs[1]);
            near("end low", lo[k], card.lows[2]);
        end
    endtask
    task automatic t_egt;
        for (int g = 0; g < 4; g++)
        begin
            setcfg(8'h0C | 8'(g), 1'b0);
            tx_frame(2);
            near("first low", 128, card.lows[0]);
            near("guard", (9 + g) * 128, card.highs[1]);
            chk("low phases", 32'h2, 32'(card.lows.size()));
        end
    endtask
    task automatic t_rx;
        int r;
        setcfg(8'h80, 1'b0);
        r = n_rx;
        card.send(1'b0, 2, 1'b1);
        card.send(1'b1, 2, 1'b1);
        repeat (4) @(posedge sys_clk_in);
        chk("start required", 32'(r + 2), 32'(n_rx));
        bus(1'b0, 8'hC0, 32'h0, 4'hF);
        chk("status", 32'h2, q);
        setcfg(8'h40, 1'b0);
        r = n_perr;
        card.send(1'b1, 1, 1'b0);
        card.send(1'b1, 1, 1'b1);
        setcfg(8'h00, 1'b0);
        card.send(1'b0, 1, 1'b0);
        repeat (4) @(posedge sys_clk_in);
        chk("error pulses", 32'(r + 1), 32'(n_perr));
        rx_data_ready_in <= 1'b0;
        card.send(1'b1, 32, 1'b1);
        @(negedge sys_clk_in);
        chk("full refuses", 32'h0, 32'(rx_byte_ready_out));
        @(posedge sys_clk_in);
        rx_data_ready_in <= 1'b1;
        for (int i = 0; i < 32; i++)
        begin
            @(negedge sys_clk_in);
            chk("drained byte", 32'hA0 + 32'(i), 32'(rx_data_out));
            @(posedge sys_clk_in);
        end
        @(negedge sys_clk_in);
        chk("drained empty", 32'h0, 32'(rx_data_valid_out));
    endtask
    initial
    begin
        repeat (12) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        t_regs();
        t_delims();
        t_egt();
        t_rx();
        wrap_up();
    end
endmodule
`default_nettype wire
